/* File: tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, r, p0, m;
	logic pready, pslverr, e, cap_valid, cap_ready, trigger, running, complete;
	logic [15:0] cap_data;
	int fails = 0;
	int checks_done = 0;
	int mval[4];
	int mocc[4];
	int nt, cur, left, rval, sel, d, nbr;
	bit chg;
	always #12.5 pclk = ~pclk;
	tts_sequencer #(.MEM_DEPTH(8), .AW(3)) u_tts_sequencer (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_valid(cap_valid),
		.cap_data(cap_data), .cap_ready(cap_ready), .trigger(trigger), .running(running),
		.complete(complete));
	tts_partner u_tts_partner (.pclk(pclk), .cap_ready(cap_ready), .cap_valid(cap_valid),
		.cap_data(cap_data));
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic hang;
		fails++;
		$display("MISMATCH %0t wait ran out", $time);
		close_out();
	endtask : hang
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
			hang();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic st(input logic [31:0] msk, input logic [31:0] x);
		apb(1'b0, tts_pkg::OFF_STATUS, 32'h0);
		cmp(r & msk, x, "status");
	endtask : st
	task automatic put(input logic [15:0] v);
		bit ok;
		u_tts_partner.send(v, ok);
		if (!ok)
			hang();
	endtask : put
	task automatic term(input int i, input int v, input int n);
		apb(1'b1, 12'h040 + 12'(8 * i), {16'hffff, 16'(v)});
		apb(1'b1, 12'h044 + 12'(8 * i), {16'(n), 16'h0002});
	endtask : term
	function automatic bit step(input int v);
		int c0;
		int l0;
		c0 = cur;
		l0 = left;
		if (v == mval[cur - 1]) begin
			if (left <= 1) begin
				nbr++;
				cur++;
				left = (cur <= nt) ? mocc[cur - 1] : 0;
			end else
				left--;
		end else if (v == rval) begin
			// a restart is a branch and is stored even when nothing moves
			nbr++;
			cur = 1;
			left = mocc[0];
		end
		return c0 != cur || l0 != left;
	endfunction : step
	initial begin
		void'($urandom(24311));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, tts_pkg::OFF_NTERMS, 32'h0);
		cmp(r, 32'h1, "nterms");
		apb(1'b0, 12'h044, 32'h0);
		cmp(r, 32'h00010001, "term1 mode");
		apb(1'b0, tts_pkg::OFF_STORE_MODE, 32'h0);
		cmp(r, 32'h1, "store mode");
		apb(1'b0, tts_pkg::OFF_RESTART_MODE, 32'h0);
		cmp(r, 32'h0, "restart mode");
		st(32'h1e0, 32'h20);
		apb(1'b0, 12'hffc, 32'h0);
		cmp({r[30:0], e}, 32'h1, "unmapped");
		$display("test defaults done");
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h1);
		put(16'($urandom));
		@(posedge pclk);
		cmp({31'h0, trigger}, 32'h1, "trigger");
		repeat (44) @(posedge pclk);
		st(32'h1ff, 32'h82);
		cmp({31'h0, trigger}, 32'h0, "trigger pulse");
		$display("test default trigger done");
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h4);
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h0208);
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h0308);
		nt = 3;
		apb(1'b0, tts_pkg::OFF_NTERMS, 32'h0);
		cmp(r, 32'h3, "nterms");
		mval = '{32'h0443, 32'h040f, 32'h05c2, 0};
		// term 2 shares the restart value so primary precedence is exercised
		rval = 32'h040f;
		for (int i = 0; i < 3; i++) begin
			mocc[i] = 1 + $urandom % 3;
			term(i, mval[i], mocc[i]);
		end
		apb(1'b1, tts_pkg::OFF_RESTART_EXPR, 32'hffff040f);
		apb(1'b1, tts_pkg::OFF_RESTART_MODE, 32'h2);
		apb(1'b1, tts_pkg::OFF_STORE_MODE, 32'h0);
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h1);
		cur = 1;
		left = mocc[0];
		nbr = 0;
		apb(1'b0, tts_pkg::OFF_WR_PTR, 32'h0);
		p0 = r;
		for (int k = 0; k < 80 && cur <= nt; k++) begin
			sel = $urandom % 5;
			d = (sel == 0) ? $urandom % 256 : mval[(sel == 4) ? 2 : sel - 1];
			u_tts_partner.slow = $urandom % 3;
			chg = step(d);
			put(16'(d));
			@(posedge pclk);
			cmp({31'h0, trigger}, {31'h0, cur > nt}, "trigger");
			m = (cur > nt) ? 32'h1f : 32'hffff001f;
			if (chg)
				st(m, 32'h18);
			repeat (45) @(posedge pclk);
			st(m, {16'(left), 16'(cur)} & m);
		end
		apb(1'b0, tts_pkg::OFF_WR_PTR, 32'h0);
		cmp((r - p0) & 32'h7, 32'(nbr) & 32'h7, "stored branches");
		apb(1'b1, tts_pkg::OFF_STORE_MODE, 32'h1);
		for (int k = 0; k < 12 && !complete; k++) begin
			put(16'($urandom));
			repeat (2) @(posedge pclk);
		end
		cmp({31'h0, complete}, 32'h1, "complete");
		st(32'h1ff, 32'h104);
		$display("test sequence done");
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h4);
		apb(1'b1, tts_pkg::OFF_SIMPLE_TRIGGER, 32'hffff1234);
		apb(1'b0, tts_pkg::OFF_SIMPLE_TRIGGER, 32'h0);
		cmp(r, 32'hffff1234, "simple trigger");
		apb(1'b0, 12'h044, 32'h0);
		cmp(r, 32'h00010002, "term1 mode");
		apb(1'b0, tts_pkg::OFF_RESTART_MODE, 32'h0);
		cmp(r, 32'h0, "restart mode");
		apb(1'b0, tts_pkg::OFF_STORE_MODE, 32'h0);
		cmp(r, 32'h1, "store mode");
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h1);
		put(16'h1235);
		repeat (45) @(posedge pclk);
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h2);
		st(32'hffff01ff, 32'h00010101);
		$display("test halt done");
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h4);
		term(0, 32'h00cc, 1);
		apb(1'b1, tts_pkg::OFF_STORE_EXPR, 32'hffff00aa);
		apb(1'b1, tts_pkg::OFF_STORE_MODE, 32'h2);
		apb(1'b1, tts_pkg::OFF_PRE_EXPR, 32'hff00bb00);
		apb(1'b1, tts_pkg::OFF_PRE_MODE, 32'h2);
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h1);
		// three prestore candidates: only the last two may survive
		put(16'hbb01);
		put(16'h0011);
		put(16'hbb02);
		put(16'hbb03);
		put(16'h00aa);
		apb(1'b0, tts_pkg::OFF_WR_PTR, 32'h0);
		cmp(r, 32'h3, "write pointer");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, tts_pkg::OFF_MEM_ADDR, 32'(i));
			apb(1'b0, tts_pkg::OFF_MEM_DATA, 32'h0);
			cmp(r, (i == 2) ? 32'h000000aa : 32'h0001bb02 + 32'(i), "memory");
		end
		$display("test prestore done");
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h4);
		repeat (5) apb(1'b1, tts_pkg::OFF_CTRL, 32'h0108);
		apb(1'b0, tts_pkg::OFF_NTERMS, 32'h0);
		cmp(r, 32'h4, "nterms max");
		apb(1'b1, tts_pkg::OFF_CTRL, 32'h0210);
		apb(1'b0, tts_pkg::OFF_NTERMS, 32'h0);
		cmp(r, 32'h3, "nterms delete");
		$display("test terms done");
		close_out();
	end
endmodule : tb_top

/* File: tts_mem.sv */
module tts_mem #(
	parameter int W = 17,
	parameter int DEPTH = 512,
	parameter int AW = 9
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic we, // write strobe
	input wire logic [AW-1:0] waddr, // write address
	input wire logic [W-1:0] wdata, // write data
	input wire logic [AW-1:0] raddr, // read address
	output logic [W-1:0] rdata // registered read data
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// array carries no reset, only the output register does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule : tts_mem

/* File: tts_partner.sv */
module tts_partner (
	input wire logic pclk, // clock
	input wire logic cap_ready, // sequencer takes the state
	output logic cap_valid, // state offered
	output logic [tts_pkg::DATA_W-1:0] cap_data // offered state
);
	timeunit 1ns;
	timeprecision 1ps;
	int slow = 0; // idle cycles before each offer
	initial begin
		cap_valid = 1'b0;
		cap_data = 16'h0000;
	end
	task automatic send(input logic [15:0] d, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge pclk);
		repeat (slow) @(posedge pclk);
		cap_valid <= 1'b1;
		cap_data <= d;
		for (n = 0; n < 200; n++) begin
			@(posedge pclk);
			if (cap_ready === 1'b1) begin
				ok = 1'b1;
				break;
			end
		end
		cap_valid <= 1'b0;
		// a released bus must not look like a repeat of the last state
		cap_data <= ~d;
	endtask : send
endmodule : tts_partner

/* File: tts_pkg.sv */
package tts_pkg;
	localparam int DATA_W = 16;
	localparam int TERMS = 4;
	localparam int OCC_W = 16;
	localparam int TERM_W = 3;
	localparam int IDX_W = 2;

	localparam logic [1:0] MODE_NEVER = 2'h0;
	localparam logic [1:0] MODE_ANY = 2'h1;
	localparam logic [1:0] MODE_MATCH = 2'h2;

	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_NTERMS = 12'h008;
	localparam logic [11:0] OFF_STORE_EXPR = 12'h00c;
	localparam logic [11:0] OFF_STORE_MODE = 12'h010;
	localparam logic [11:0] OFF_RESTART_EXPR = 12'h014;
	localparam logic [11:0] OFF_RESTART_MODE = 12'h018;
	localparam logic [11:0] OFF_PRE_EXPR = 12'h01c;
	localparam logic [11:0] OFF_PRE_MODE = 12'h020;
	localparam logic [11:0] OFF_MEM_ADDR = 12'h024;
	localparam logic [11:0] OFF_MEM_DATA = 12'h028;
	localparam logic [11:0] OFF_WR_PTR = 12'h02c;
	localparam logic [11:0] OFF_SIMPLE_TRIGGER = 12'h030;
	// terms sit at 0x40 + 8*index: +0 value/mask, +4 mode and occurrence count
	localparam logic [6:0] TERM_BLOCK = 7'h02;

	localparam int CTRL_START = 0;
	localparam int CTRL_HALT = 1;
	localparam int CTRL_SEQ_RESET = 2;
	localparam int CTRL_INSERT = 3;
	localparam int CTRL_DELETE = 4;
	localparam int CTRL_IDX_LO = 8;
	localparam int EXPR_MASK_LO = 16;
	localparam int OCC_LO = 16;
	localparam int ST_TERM_UNK = 3;
	localparam int ST_OCC_UNK = 4;
	localparam int ST_STATE_LO = 5;
	localparam int ST_OCC_LO = 16;

	localparam logic [TERM_W-1:0] RST_NTERMS = 3'h1;
	localparam logic [OCC_W-1:0] RST_OCC = 16'h0001;
	localparam logic [DATA_W-1:0] RST_VAL = 16'h0000;
	localparam logic [DATA_W-1:0] RST_MASK = 16'hffff;

	localparam int CLK_PERIOD_NS = 25;
	localparam int STABLE_NS = 1000;
	localparam int STABLE_CYC = (STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_RUN = 4'b0010,
		S_FILL = 4'b0100,
		S_DONE = 4'b1000
	} tts_state_e;
endpackage : tts_pkg

/* File: tts_props.sv */
module tts_props (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic cap_ready, // state taken
	input wire logic trigger, // trigger pulse
	input wire logic running, // acquisition active
	input wire logic complete // acquisition stopped
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic ctrl_wr;
	assign ctrl_wr = psel && penable && pwrite && paddr == tts_pkg::OFF_CTRL;
	sequence s_start;
		ctrl_wr && pwdata[2:0] == 3'h1;
	endsequence
	sequence s_halt;
		running && ctrl_wr && pwdata[2:0] == 3'h2;
	endsequence
	// only a control write may end acquisition early
	sequence s_self_stop;
		running && !ctrl_wr ##1 !running;
	endsequence
	property p_start;
		s_start |=> running;
	endproperty
	property p_halt;
		s_halt |=> complete && !running;
	endproperty
	property p_seq_reset;
		ctrl_wr && pwdata[2:0] == 3'h4 |=> !running && !complete && !trigger;
	endproperty
	property p_excl;
		!(running && complete);
	endproperty
	property p_take;
		cap_ready |-> running;
	endproperty
	property p_trig_state;
		trigger |-> running || complete;
	endproperty
	property p_trig_pulse;
		trigger |=> !trigger;
	endproperty
	property p_stop;
		s_self_stop |-> complete;
	endproperty
	a_start: assert property (p_start) else $error("start did not run");
	a_halt: assert property (p_halt) else $error("halt did not stop");
	a_seq_reset: assert property (p_seq_reset) else $error("reset left state");
	a_excl: assert property (p_excl) else $error("running and complete");
	a_take: assert property (p_take) else $error("state taken while idle");
	a_trig_state: assert property (p_trig_state) else $error("trigger while idle");
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than one cycle");
	a_stop: assert property (p_stop) else $error("stopped without done");
endmodule : tts_props

bind tts_sequencer tts_props u_tts_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.cap_ready(cap_ready), .trigger(trigger), .running(running), .complete(complete));

/* File: tts_sequencer.sv */
module tts_sequencer #(
	parameter int MEM_DEPTH = 512,
	parameter int AW = 9
) (
	input wire logic pclk, // clock, 40 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic cap_valid, // captured bus state present
	input wire logic [tts_pkg::DATA_W-1:0] cap_data, // captured bus state
	output logic cap_ready, // state taken this cycle
	output logic trigger, // one-cycle trigger pulse
	output logic running, // acquisition active
	output logic complete // acquisition stopped
);
	localparam int MW = tts_pkg::DATA_W + 1;
	localparam int PW = AW + 2;

	if (MEM_DEPTH != 2 ** AW || AW < 2 || AW > 16) begin : g_bad_depth
		$error("MEM_DEPTH must be 2**AW with AW in 2..16");
	end

	logic [tts_pkg::DATA_W-1:0] t_val [tts_pkg::TERMS];
	logic [tts_pkg::DATA_W-1:0] t_msk [tts_pkg::TERMS];
	logic [1:0] t_mode [tts_pkg::TERMS];
	logic [tts_pkg::OCC_W-1:0] t_occ [tts_pkg::TERMS];
	logic [tts_pkg::DATA_W-1:0] next_t_val [tts_pkg::TERMS];
	logic [tts_pkg::DATA_W-1:0] next_t_msk [tts_pkg::TERMS];
	logic [1:0] next_t_mode [tts_pkg::TERMS];
	logic [tts_pkg::OCC_W-1:0] next_t_occ [tts_pkg::TERMS];
	logic [tts_pkg::TERM_W-1:0] nterms, next_nterms;
	logic [31:0] sto_expr, rst_expr, pre_expr;
	logic [31:0] next_sto_expr, next_rst_expr, next_pre_expr;
	logic [1:0] sto_mode, rst_mode, pre_mode;
	logic [1:0] next_sto_mode, next_rst_mode, next_pre_mode;
	logic [AW-1:0] mem_raddr, next_mem_raddr;
	logic [31:0] next_prdata;
	logic next_pslverr;

	tts_pkg::tts_state_e st, next_st;
	logic [tts_pkg::TERM_W-1:0] cur, next_cur;
	logic [tts_pkg::OCC_W-1:0] occ_left, next_occ;
	logic [AW-1:0] wp, next_wp, fl_base, next_fl_base;
	logic [PW-1:0] post, next_post;
	logic [1:0] pc, next_pc, fl_cnt, next_fl_cnt;
	logic fl_idx, next_fl_idx;
	logic [tts_pkg::DATA_W-1:0] pbuf [2];
	logic [tts_pkg::DATA_W-1:0] next_pbuf [2];
	logic next_trig;
	logic [7:0] stab, next_stab;

	logic mem_we;
	logic [AW-1:0] mem_waddr;
	logic [MW-1:0] mem_wdata, mem_rdata;

	logic wr, setup, term_hit, reg_ok;
	logic cmd_start, cmd_halt, cmd_sreset, cmd_ins, cmd_del, cmd_simple;
	logic [tts_pkg::TERM_W-1:0] cmd_idx;
	logic [tts_pkg::IDX_W-1:0] ti, ci;
	logic take, prim, rst, sto, pre, branch, store, last;
	logic [31:0] status;

	function automatic logic expr_hit(input logic [1:0] mode, input logic [31:0] ex,
			input logic [tts_pkg::DATA_W-1:0] d);
		logic [tts_pkg::DATA_W-1:0] v;
		logic [tts_pkg::DATA_W-1:0] m;
		v = ex[tts_pkg::DATA_W-1:0];
		m = ex[tts_pkg::EXPR_MASK_LO +: tts_pkg::DATA_W];
		case (mode)
			tts_pkg::MODE_ANY: expr_hit = 1'b1;
			tts_pkg::MODE_MATCH: expr_hit = ((d ^ v) & m) == '0;
			default: expr_hit = 1'b0;
		endcase
	endfunction : expr_hit

	// a count of zero behaves as one so a term can always be left
	function automatic logic [tts_pkg::OCC_W-1:0] eff_occ(input logic [tts_pkg::OCC_W-1:0] c);
		eff_occ = (c == '0) ? tts_pkg::RST_OCC : c;
	endfunction : eff_occ

	assign wr = psel && penable && pwrite;
	assign setup = psel && !penable;
	assign pready = 1'b1;
	assign term_hit = paddr[11:5] == tts_pkg::TERM_BLOCK;
	assign ti = paddr[4:3];
	assign cmd_start = wr && paddr == tts_pkg::OFF_CTRL && pwdata[tts_pkg::CTRL_START];
	assign cmd_halt = wr && paddr == tts_pkg::OFF_CTRL && pwdata[tts_pkg::CTRL_HALT];
	assign cmd_sreset = wr && paddr == tts_pkg::OFF_CTRL && pwdata[tts_pkg::CTRL_SEQ_RESET];
	assign cmd_ins = wr && paddr == tts_pkg::OFF_CTRL && pwdata[tts_pkg::CTRL_INSERT];
	assign cmd_del = wr && paddr == tts_pkg::OFF_CTRL && pwdata[tts_pkg::CTRL_DELETE];
	assign cmd_idx = pwdata[tts_pkg::CTRL_IDX_LO +: tts_pkg::TERM_W];
	assign cmd_simple = wr && paddr == tts_pkg::OFF_SIMPLE_TRIGGER;

	assign ci = IDX_W_CAST(cur);
	function automatic logic [tts_pkg::IDX_W-1:0] IDX_W_CAST(input logic [tts_pkg::TERM_W-1:0] t);
		logic [tts_pkg::TERM_W-1:0] z;
		z = t - 3'h1;
		IDX_W_CAST = z[tts_pkg::IDX_W-1:0];
	endfunction : IDX_W_CAST

	assign cap_ready = (st == tts_pkg::S_RUN || st == tts_pkg::S_FILL) && fl_cnt == 2'h0;
	assign take = cap_valid && cap_ready;
	assign prim = expr_hit(t_mode[ci], {t_msk[ci], t_val[ci]}, cap_data);
	assign rst = expr_hit(rst_mode, rst_expr, cap_data);
	assign sto = expr_hit(sto_mode, sto_expr, cap_data);
	assign pre = expr_hit(pre_mode, pre_expr, cap_data);
	assign last = occ_left <= tts_pkg::RST_OCC;
	assign branch = (st == tts_pkg::S_RUN) && (prim ? last : rst);
	assign store = sto || branch;
	assign running = st == tts_pkg::S_RUN || st == tts_pkg::S_FILL;
	assign complete = st == tts_pkg::S_DONE;

	always_comb begin
		status = '0;
		status[tts_pkg::ST_STATE_LO +: 4] = st;
		// a value that keeps moving is useless to software; flag it instead
		if (running && stab < 8'(tts_pkg::STABLE_CYC)) begin
			status[tts_pkg::ST_TERM_UNK] = 1'b1;
			status[tts_pkg::ST_OCC_UNK] = 1'b1;
		end else begin
			status[tts_pkg::TERM_W-1:0] = cur;
			status[tts_pkg::ST_OCC_LO +: tts_pkg::OCC_W] = occ_left;
		end
	end

	always_comb begin
		next_t_val = t_val;
		next_t_msk = t_msk;
		next_t_mode = t_mode;
		next_t_occ = t_occ;
		next_nterms = nterms;
		next_sto_expr = sto_expr;
		next_sto_mode = sto_mode;
		next_rst_expr = rst_expr;
		next_rst_mode = rst_mode;
		next_pre_expr = pre_expr;
		next_pre_mode = pre_mode;
		next_mem_raddr = mem_raddr;
		if (cmd_sreset) begin
			next_nterms = tts_pkg::RST_NTERMS;
			next_t_val[0] = tts_pkg::RST_VAL;
			next_t_msk[0] = tts_pkg::RST_MASK;
			next_t_mode[0] = tts_pkg::MODE_ANY;
			next_t_occ[0] = tts_pkg::RST_OCC;
			next_sto_mode = tts_pkg::MODE_ANY;
			next_rst_mode = tts_pkg::MODE_NEVER;
			next_pre_mode = tts_pkg::MODE_NEVER;
		end else if (cmd_ins && nterms < 3'(tts_pkg::TERMS) && cmd_idx != 3'h0
				&& cmd_idx <= nterms + 3'h1) begin
			for (int i = tts_pkg::TERMS - 1; i > 0; i--) begin
				if (3'(i) >= cmd_idx) begin
					next_t_val[i] = t_val[i-1];
					next_t_msk[i] = t_msk[i-1];
					next_t_mode[i] = t_mode[i-1];
					next_t_occ[i] = t_occ[i-1];
				end
			end
			next_t_val[IDX_W_CAST(cmd_idx)] = tts_pkg::RST_VAL;
			next_t_msk[IDX_W_CAST(cmd_idx)] = tts_pkg::RST_MASK;
			next_t_mode[IDX_W_CAST(cmd_idx)] = tts_pkg::MODE_ANY;
			next_t_occ[IDX_W_CAST(cmd_idx)] = tts_pkg::RST_OCC;
			next_nterms = nterms + 3'h1;
		end else if (cmd_del && nterms > 3'h1 && cmd_idx != 3'h0 && cmd_idx <= nterms) begin
			for (int i = 0; i < tts_pkg::TERMS - 1; i++) begin
				if (3'(i) >= cmd_idx - 3'h1) begin
					next_t_val[i] = t_val[i+1];
					next_t_msk[i] = t_msk[i+1];
					next_t_mode[i] = t_mode[i+1];
					next_t_occ[i] = t_occ[i+1];
				end
			end
			next_nterms = nterms - 3'h1;
		end else if (cmd_simple) begin
			next_t_val[0] = pwdata[tts_pkg::DATA_W-1:0];
			next_t_msk[0] = pwdata[tts_pkg::EXPR_MASK_LO +: tts_pkg::DATA_W];
			next_t_mode[0] = tts_pkg::MODE_MATCH;
		end else if (wr && term_hit && !paddr[2]) begin
			next_t_val[ti] = pwdata[tts_pkg::DATA_W-1:0];
			next_t_msk[ti] = pwdata[tts_pkg::EXPR_MASK_LO +: tts_pkg::DATA_W];
		end else if (wr && term_hit) begin
			next_t_mode[ti] = pwdata[1:0];
			next_t_occ[ti] = pwdata[tts_pkg::OCC_LO +: tts_pkg::OCC_W];
		end else if (wr) begin
			case (paddr)
				tts_pkg::OFF_STORE_EXPR: next_sto_expr = pwdata;
				tts_pkg::OFF_STORE_MODE: next_sto_mode = pwdata[1:0];
				tts_pkg::OFF_RESTART_EXPR: next_rst_expr = pwdata;
				tts_pkg::OFF_RESTART_MODE: next_rst_mode = pwdata[1:0];
				tts_pkg::OFF_PRE_EXPR: next_pre_expr = pwdata;
				tts_pkg::OFF_PRE_MODE: next_pre_mode = pwdata[1:0];
				tts_pkg::OFF_MEM_ADDR: next_mem_raddr = pwdata[AW-1:0];
				default: next_nterms = nterms;
			endcase
		end
		reg_ok = 1'b1;
		next_prdata = '0;
		if (term_hit && !paddr[2]) begin
			next_prdata = {t_msk[ti], t_val[ti]};
		end else if (term_hit) begin
			next_prdata = {t_occ[ti], 14'h0000, t_mode[ti]};
		end else begin
			case (paddr)
				tts_pkg::OFF_CTRL: next_prdata = '0;
				tts_pkg::OFF_SIMPLE_TRIGGER: next_prdata = {t_msk[0], t_val[0]};
				tts_pkg::OFF_STATUS: next_prdata = status;
				tts_pkg::OFF_NTERMS: next_prdata = {29'h0, nterms};
				tts_pkg::OFF_STORE_EXPR: next_prdata = sto_expr;
				tts_pkg::OFF_STORE_MODE: next_prdata = {30'h0, sto_mode};
				tts_pkg::OFF_RESTART_EXPR: next_prdata = rst_expr;
				tts_pkg::OFF_RESTART_MODE: next_prdata = {30'h0, rst_mode};
				tts_pkg::OFF_PRE_EXPR: next_prdata = pre_expr;
				tts_pkg::OFF_PRE_MODE: next_prdata = {30'h0, pre_mode};
				tts_pkg::OFF_MEM_ADDR: next_prdata = 32'(mem_raddr);
				tts_pkg::OFF_MEM_DATA: next_prdata = 32'(mem_rdata);
				tts_pkg::OFF_WR_PTR: next_prdata = 32'(wp);
				default: reg_ok = 1'b0;
			endcase
		end
		next_pslverr = !reg_ok;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < tts_pkg::TERMS; i++) begin
				t_val[i] <= tts_pkg::RST_VAL;
				t_msk[i] <= tts_pkg::RST_MASK;
				t_mode[i] <= tts_pkg::MODE_ANY;
				t_occ[i] <= tts_pkg::RST_OCC;
			end
			nterms <= tts_pkg::RST_NTERMS;
			sto_expr <= '0;
			sto_mode <= tts_pkg::MODE_ANY;
			rst_expr <= '0;
			rst_mode <= tts_pkg::MODE_NEVER;
			pre_expr <= '0;
			pre_mode <= tts_pkg::MODE_NEVER;
			mem_raddr <= '0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			t_val <= next_t_val;
			t_msk <= next_t_msk;
			t_mode <= next_t_mode;
			t_occ <= next_t_occ;
			nterms <= next_nterms;
			sto_expr <= next_sto_expr;
			sto_mode <= next_sto_mode;
			rst_expr <= next_rst_expr;
			rst_mode <= next_rst_mode;
			pre_expr <= next_pre_expr;
			pre_mode <= next_pre_mode;
			mem_raddr <= next_mem_raddr;
			// read data is sampled in the setup phase and held through access
			if (setup) begin
				prdata <= next_prdata;
				pslverr <= next_pslverr;
			end
		end
	end

	always_comb begin
		next_st = st;
		next_cur = cur;
		next_occ = occ_left;
		next_wp = wp;
		next_post = post;
		next_pc = pc;
		next_pbuf = pbuf;
		next_fl_cnt = fl_cnt;
		next_fl_base = fl_base;
		next_fl_idx = fl_idx;
		next_trig = 1'b0;
		mem_we = 1'b0;
		mem_waddr = wp;
		mem_wdata = {1'b0, cap_data};
		if (cmd_start) begin
			next_st = tts_pkg::S_RUN;
			next_cur = 3'h1;
			next_occ = eff_occ(t_occ[0]);
			next_wp = '0;
			next_post = '0;
			next_pc = 2'h0;
			next_fl_cnt = 2'h0;
		end else if (cmd_halt && running) begin
			next_st = tts_pkg::S_DONE;
		end else if (cmd_sreset) begin
			next_st = tts_pkg::S_IDLE;
			next_cur = 3'h1;
			next_occ = tts_pkg::RST_OCC;
		end else begin
			if (fl_cnt != 2'h0) begin
				// prestored states land in the slots held ahead of the stored state
				mem_we = 1'b1;
				mem_waddr = fl_base + AW'(fl_idx);
				mem_wdata = {1'b1, pbuf[fl_idx]};
				next_fl_idx = !fl_idx;
				next_fl_cnt = fl_cnt - 2'h1;
				if (fl_cnt == 2'h1) begin
					next_pc = 2'h0;
				end
			end else if (take) begin
				if (branch && prim) begin
					if (cur >= nterms) begin
						next_cur = nterms + 3'h1;
						next_st = tts_pkg::S_FILL;
						next_trig = 1'b1;
						next_post = PW'(pc) + PW'(1);
					end else begin
						next_cur = cur + 3'h1;
						next_occ = eff_occ(t_occ[IDX_W_CAST(cur + 3'h1)]);
					end
				end else if (branch) begin
					next_cur = 3'h1;
					next_occ = eff_occ(t_occ[0]);
				end else if (prim && st == tts_pkg::S_RUN) begin
					next_occ = occ_left - 16'h0001;
				end
				if (store) begin
					mem_we = 1'b1;
					mem_waddr = wp + AW'(pc);
					next_wp = wp + AW'(pc) + AW'(1);
					next_fl_base = wp;
					next_fl_idx = 1'b0;
					next_fl_cnt = pc;
					if (st == tts_pkg::S_FILL) begin
						next_post = post + PW'(pc) + PW'(1);
					end
				end else if (pre && pre_mode != tts_pkg::MODE_NEVER) begin
					// only the two most recent prestore states survive
					if (pc == 2'h2) begin
						next_pbuf[0] = pbuf[1];
						next_pbuf[1] = cap_data;
					end else begin
						next_pbuf[pc[0]] = cap_data;
						next_pc = pc + 2'h1;
					end
				end
			end
			if (st == tts_pkg::S_FILL && fl_cnt == 2'h0 && post >= PW'(MEM_DEPTH)) begin
				next_st = tts_pkg::S_DONE;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= tts_pkg::S_IDLE;
			cur <= 3'h1;
			occ_left <= tts_pkg::RST_OCC;
			wp <= '0;
			post <= '0;
			pc <= 2'h0;
			pbuf[0] <= '0;
			pbuf[1] <= '0;
			fl_cnt <= 2'h0;
			fl_base <= '0;
			fl_idx <= 1'b0;
			stab <= 8'h0;
			trigger <= 1'b0;
		end else begin
			st <= next_st;
			cur <= next_cur;
			occ_left <= next_occ;
			wp <= next_wp;
			post <= next_post;
			pc <= next_pc;
			pbuf <= next_pbuf;
			fl_cnt <= next_fl_cnt;
			fl_base <= next_fl_base;
			fl_idx <= next_fl_idx;
			stab <= next_stab;
			// registered so the pulse is one clean cycle after the branching state
			trigger <= next_trig;
		end
	end

	always_comb begin
		next_stab = stab;
		if (next_cur != cur || next_occ != occ_left) begin
			next_stab = 8'h0;
		end else if (stab < 8'(tts_pkg::STABLE_CYC)) begin
			next_stab = stab + 8'h1;
		end
	end

	tts_mem #(
		.W(MW),
		.DEPTH(MEM_DEPTH),
		.AW(AW)
	) u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);
endmodule : tts_sequencer
